/* File: rtl/ddrbc_core.sv */
module ddrbc_core
    import ddrbc_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic cke_in,
    input wire logic cs_n_in,
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic we_n_in,
    input wire logic [BA_W-1:0] ba_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic otf_en_in,
    input wire logic mrs_burst8_in,
    input wire logic [DQ_W-1:0] wdata_in,
    input wire logic [DM_W-1:0] dm_in,
    input wire logic wdata_valid_in,
    output logic wdata_ready_out,
    output logic [NUM_BANKS-1:0] bank_open_out,
    output logic busy_out,
    output logic self_refresh_out,
    output logic [ROW_W-1:0] refresh_row_out,
    output logic rd_beat_out,
    output logic [COL_W-1:0] rd_col_out,
    output logic [BA_W-1:0] rd_bank_out,
    output logic wr_beat_out,
    output logic [COL_W-1:0] wr_col_out,
    output logic [BA_W-1:0] wr_bank_out,
    output logic [ROW_W-1:0] wr_row_out,
    output logic [DQ_W-1:0] wr_data_out,
    output logic [DM_W-1:0] wr_byte_en_out
);
    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [BA_W+ADDR_W+6:0] pin_s1_r;
    logic [BA_W+ADDR_W+6:0] pin_s2_r;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            pin_s1_r <= {cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in, otf_en_in,
                         mrs_burst8_in, ba_in, addr_in};
            pin_s2_r <= pin_s1_r;
        end
    end
    logic cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, otf_s, mrs8_s;
    logic [BA_W-1:0] ba_s;
    logic [ADDR_W-1:0] a_s;
    assign {cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, otf_s, mrs8_s, ba_s, a_s} = pin_s2_r;

    // ------------------------------------------------------------------
    // Write data buffer
    // ------------------------------------------------------------------
    logic [DQ_W+DM_W-1:0] fifo_q;
    logic fifo_valid;
    logic fifo_pop;
    ddrbc_fifo #(.WIDTH(DQ_W + DM_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .wr_data_in({dm_in, wdata_in}),
        .wr_valid_in(wdata_valid_in),
        .wr_ready_out(wdata_ready_out),
        .rd_data_out(fifo_q),
        .rd_valid_out(fifo_valid),
        .rd_ready_in(fifo_pop)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        ddrbc_state_t st;
        logic [NUM_BANKS-1:0] open;
        logic [NUM_BANKS-1:0][ROW_W-1:0] row;
        logic [BA_W-1:0] bank;
        logic [COL_W-1:0] col;
        logic [3:0] beat;
        logic [3:0] last;
        logic ap;
        logic [ROW_W-1:0] ref_row;
        logic [12:0] sr_cnt;
        logic rd_beat;
        logic wr_beat;
        logic [COL_W-1:0] out_col;
        logic [BA_W-1:0] out_bank;
        logic [ROW_W-1:0] out_row;
        logic [DQ_W-1:0] out_data;
        logic [DM_W-1:0] out_be;
        logic busy;
        logic sr;
    } ddrbc_core_t;
    ddrbc_core_t s_r;
    ddrbc_core_t s_nxt;

    ddrbc_cmd_t cmd;
    always_comb begin
        cmd = DDRBC_CMD_NOP;
        if (cke_s && !cs_n_s) begin
            case ({ras_n_s, cas_n_s, we_n_s})
                3'b011: cmd = DDRBC_CMD_ACT;
                3'b101: cmd = DDRBC_CMD_RD;
                3'b100: cmd = DDRBC_CMD_WR;
                3'b010: cmd = DDRBC_CMD_PRE;
                3'b001: cmd = DDRBC_CMD_REF;
                3'b111: cmd = DDRBC_CMD_NOP;
                default: cmd = DDRBC_CMD_OTH;
            endcase
        end
    end
    // Self refresh entry is REFRESH with CKE dropping, seen one cycle late
    logic cke_d_r;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cke_d_r <= 1'b0;
        end else begin
            cke_d_r <= cke_s;
        end
    end
    logic sre;
    assign sre = cke_d_r && !cke_s && !cs_n_s && !ras_n_s && !cas_n_s && we_n_s;

    logic b8;
    logic [COL_W-1:0] seq_col;
    logic [2:0] low;
    always_comb begin
        b8 = otf_s ? a_s[A12_POS] : mrs8_s;
        low = s_r.col[2:0] + s_r.beat[2:0];
        // Chopped bursts wrap within their four-column half
        seq_col = (s_r.last == BEAT4_LAST) ? {s_r.col[COL_W-1:2], low[1:0]} :
                  {s_r.col[COL_W-1:3], low};
    end
    assign fifo_pop = (s_r.st == DDRBC_ST_WRITE) && fifo_valid;

    always_comb begin
        s_nxt = s_r;
        s_nxt.rd_beat = 1'b0;
        s_nxt.wr_beat = 1'b0;
        case (s_r.st)
            DDRBC_ST_READ: begin
                // Burst cannot be cut short by any new command
                s_nxt.rd_beat = 1'b1;
                s_nxt.out_col = seq_col;
                s_nxt.out_bank = s_r.bank;
                s_nxt.beat = s_r.beat + 4'h1;
                if (s_r.beat == s_r.last) begin
                    s_nxt.st = DDRBC_ST_IDLE;
                    if (s_r.ap) begin
                        s_nxt.open[s_r.bank] = 1'b0;
                    end
                end
            end
            DDRBC_ST_WRITE: begin
                if (fifo_valid) begin
                    s_nxt.wr_beat = 1'b1;
                    s_nxt.out_col = seq_col;
                    s_nxt.out_bank = s_r.bank;
                    s_nxt.out_row = s_r.row[s_r.bank];
                    s_nxt.out_data = fifo_q[DQ_W-1:0];
                    s_nxt.out_be = ~fifo_q[DQ_W+DM_W-1:DQ_W];
                    s_nxt.beat = s_r.beat + 4'h1;
                    if (s_r.beat == s_r.last) begin
                        s_nxt.st = DDRBC_ST_IDLE;
                        if (s_r.ap) begin
                            s_nxt.open[s_r.bank] = 1'b0;
                        end
                    end
                end
            end
            DDRBC_ST_SELF: begin
                // Internal timer keeps refreshing rows with no commands
                if (s_r.sr_cnt == 13'h0000) begin
                    s_nxt.sr_cnt = SELF_REF_CNT;
                    s_nxt.ref_row = s_r.ref_row + 1'b1;
                end else begin
                    s_nxt.sr_cnt = s_r.sr_cnt - 13'h0001;
                end
                if (cke_s) begin
                    s_nxt.st = DDRBC_ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = DDRBC_ST_IDLE;
            end
        endcase
        if (s_r.st != DDRBC_ST_SELF) begin
            if (sre && s_r.st == DDRBC_ST_IDLE) begin
                s_nxt.st = DDRBC_ST_SELF;
                s_nxt.sr_cnt = SELF_REF_CNT;
            end
            case (cmd)
                DDRBC_CMD_ACT: begin
                    s_nxt.open[ba_s] = 1'b1;
                    s_nxt.row[ba_s] = a_s[ROW_W-1:0];
                end
                DDRBC_CMD_RD, DDRBC_CMD_WR: begin
                    if (s_r.st == DDRBC_ST_IDLE && s_r.open[ba_s]) begin
                        s_nxt.st = (cmd == DDRBC_CMD_RD) ? DDRBC_ST_READ : DDRBC_ST_WRITE;
                        s_nxt.bank = ba_s;
                        s_nxt.col = a_s[COL_W-1:0];
                        s_nxt.ap = a_s[A10_POS];
                        s_nxt.beat = 4'h0;
                        s_nxt.last = b8 ? BEAT8_LAST : BEAT4_LAST;
                    end
                end
                DDRBC_CMD_PRE: begin
                    // Closing an idle bank changes nothing, acting as a nop
                    if (a_s[A10_POS]) begin
                        s_nxt.open = '0;
                    end else begin
                        s_nxt.open[ba_s] = 1'b0;
                    end
                end
                DDRBC_CMD_REF: begin
                    s_nxt.ref_row = s_r.ref_row + 1'b1;
                end
                default: begin
                end
            endcase
        end
        // Status bits follow the next state so they register with it
        s_nxt.busy = (s_nxt.st == DDRBC_ST_READ) || (s_nxt.st == DDRBC_ST_WRITE);
        s_nxt.sr = (s_nxt.st == DDRBC_ST_SELF);
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_r <= '0;
            s_r.st <= DDRBC_ST_IDLE;
            s_r.ref_row <= REF_ROW_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bank_open_out = s_r.open;
    assign busy_out = s_r.busy;
    assign self_refresh_out = s_r.sr;
    assign refresh_row_out = s_r.ref_row;
    assign rd_beat_out = s_r.rd_beat;
    assign rd_col_out = s_r.out_col;
    assign rd_bank_out = s_r.out_bank;
    assign wr_beat_out = s_r.wr_beat;
    assign wr_col_out = s_r.out_col;
    assign wr_bank_out = s_r.out_bank;
    assign wr_row_out = s_r.out_row;
    assign wr_data_out = s_r.out_data;
    assign wr_byte_en_out = s_r.out_be;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence seq_rd_start;
        s_r.st == DDRBC_ST_IDLE && cmd == DDRBC_CMD_RD && s_r.open[ba_s];
    endsequence
    AST_RD_BEATS: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        seq_rd_start ##0 !b8 |=> ##1 rd_beat_out [*4] ##1 !rd_beat_out)
        else $error("chopped read burst length wrong");
    AST_RD8_BEATS: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        seq_rd_start ##0 b8 |=> ##1 rd_beat_out [*8])
        else $error("eight beat read burst length wrong");
    AST_ACT_OPEN: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        cmd == DDRBC_CMD_ACT && s_r.st != DDRBC_ST_SELF |=> bank_open_out[$past(ba_s)])
        else $error("activate did not open bank");
    AST_PRE_ALL: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        cmd == DDRBC_CMD_PRE && a_s[A10_POS] && s_r.st == DDRBC_ST_IDLE
        |=> bank_open_out == '0)
        else $error("precharge all left a bank open");
    AST_REF_ROW: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        cmd == DDRBC_CMD_REF && s_r.st != DDRBC_ST_SELF
        |=> refresh_row_out == $past(refresh_row_out) + 1'b1)
        else $error("refresh row not advanced");
    AST_WR_MASK: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        fifo_pop |=> wr_byte_en_out == ~$past(fifo_q[DQ_W+DM_W-1:DQ_W]))
        else $error("byte enable not inverse of mask");
    AST_RD_COL: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        seq_rd_start |=> ##1 rd_col_out == $past(a_s[COL_W-1:0], 2))
        else $error("first read column wrong");
    AST_AP_CLOSE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        s_r.st == DDRBC_ST_READ && s_r.beat == s_r.last && s_r.ap && cmd != DDRBC_CMD_ACT
        |=> !bank_open_out[$past(s_r.bank)])
        else $error("auto precharge did not close bank");
endmodule : ddrbc_core

/* File: rtl/ddrbc_pkg.sv */
package ddrbc_pkg;
    localparam int NUM_BANKS = 8;
    localparam int BA_W = 3;
    localparam int ROW_W = 14;
    localparam int COL_W = 10;
    localparam int DQ_W = 16;
    localparam int DM_W = 2;
    localparam int ADDR_W = 14;
    localparam int A10_POS = 10;
    localparam int A12_POS = 12;
    localparam int BURST8_BEATS = 8;
    localparam int BURST4_BEATS = 4;
    localparam logic [3:0] BEAT8_LAST = 4'h7;
    localparam logic [3:0] BEAT4_LAST = 4'h3;
    localparam int FIFO_DEPTH = 8;
    localparam logic [ROW_W-1:0] ROW_RST = 14'h0000;
    localparam logic [ROW_W-1:0] REF_ROW_RST = 14'h0000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SELF_REF_INTERVAL_NS = 7800;
    localparam int SELF_REF_CYCLES = SELF_REF_INTERVAL_NS / CLK_PERIOD_NS;
    localparam logic [12:0] SELF_REF_CNT = 13'(SELF_REF_CYCLES - 1);
    typedef enum logic [2:0] {
        DDRBC_CMD_NOP = 3'h0,
        DDRBC_CMD_ACT = 3'h1,
        DDRBC_CMD_RD = 3'h2,
        DDRBC_CMD_WR = 3'h3,
        DDRBC_CMD_PRE = 3'h4,
        DDRBC_CMD_REF = 3'h5,
        DDRBC_CMD_SRE = 3'h6,
        DDRBC_CMD_OTH = 3'h7
    } ddrbc_cmd_t;
    typedef enum logic [1:0] {
        DDRBC_ST_IDLE = 2'b00,
        DDRBC_ST_READ = 2'b01,
        DDRBC_ST_WRITE = 2'b11,
        DDRBC_ST_SELF = 2'b10
    } ddrbc_state_t;
endpackage : ddrbc_pkg

/* File: rtl/ddrbc_fifo.sv */
module ddrbc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    logic room_r;
    logic avail_r;
    logic [AW:0] wp_nxt;
    logic [AW:0] rp_nxt;
    // Flags come from the next pointers so that ready leaves a flip-flop
    always_comb begin
        wp_nxt = wp_r + {{AW{1'b0}}, (wr_valid_in && room_r)};
        rp_nxt = rp_r + {{AW{1'b0}}, (rd_ready_in && avail_r)};
    end
    assign wr_ready_out = room_r;
    assign rd_valid_out = avail_r;
    assign rd_data_out = mem_r[rp_r[AW-1:0]];
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wp_r <= '0;
            rp_r <= '0;
            room_r <= 1'b1;
            avail_r <= 1'b0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            room_r <= (wp_nxt[AW] == rp_nxt[AW]) || (wp_nxt[AW-1:0] != rp_nxt[AW-1:0]);
            avail_r <= (wp_nxt != rp_nxt);
        end
    end
    always_ff @(posedge clk_in) begin
        if (wr_valid_in && room_r) begin
            mem_r[wp_r[AW-1:0]] <= wr_data_in;
        end
    end
endmodule : ddrbc_fifo

/* File: verification/ddrbc_ctrl_model.sv */
module ddrbc_ctrl_model
    import ddrbc_pkg::*;
#(
    parameter int REF_GAP = 8
) (
    input wire logic clk_in,
    output logic cke_out,
    output logic cs_n_out,
    output logic ras_n_out,
    output logic cas_n_out,
    output logic we_n_out,
    output logic [BA_W-1:0] ba_out,
    output logic [ADDR_W-1:0] addr_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int VREF_SETTLE = 512;
    int wr_hold;
    initial begin
        cke_out = 1'b1;
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hf;
        ba_out = '0;
        addr_out = '0;
        wr_hold = 0;
    end
    // Holds back the first write after self refresh exit
    always @(posedge clk_in) begin
        if (cke_out && wr_hold > 0) begin
            wr_hold <= wr_hold - 1;
        end
    end
    // --------------------------------------------------------------
    // One command for one cycle, then deselect
    // --------------------------------------------------------------
    task automatic issue(input ddrbc_cmd_t c, input logic [BA_W-1:0] b,
                         input logic [ADDR_W-1:0] a);
        logic [3:0] p;
        case (c)
            DDRBC_CMD_ACT: p = 4'h3;
            DDRBC_CMD_RD: p = 4'h5;
            DDRBC_CMD_WR: p = 4'h4;
            DDRBC_CMD_PRE: p = 4'h2;
            DDRBC_CMD_REF, DDRBC_CMD_SRE: p = 4'h1;
            default: p = 4'h7;
        endcase
        while (c == DDRBC_CMD_WR && wr_hold > 0) begin
            @(posedge clk_in);
        end
        @(posedge clk_in);
        #1;
        if (c == DDRBC_CMD_SRE) begin
            wr_hold = VREF_SETTLE;
        end
        cke_out = (c != DDRBC_CMD_SRE);
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = p;
        ba_out = b;
        addr_out = a;
        @(posedge clk_in);
        #1;
        // Released lines show the inverse of the last value
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = {1'b1, ~p[2:0]};
        ba_out = ~ba_out;
        addr_out = ~addr_out;
        if (c == DDRBC_CMD_REF) begin
            repeat (REF_GAP) @(posedge clk_in);
        end
    endtask : issue
endmodule : ddrbc_ctrl_model

/* File: verification/tb_ddr3_bank_command_logic.sv */
module tb_ddr3_bank_command_logic
    import ddrbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [2:0] ba; logic [13:0] row; logic [9:0] col;
        logic a12; logic otf; logic b8; logic ap; logic [3:0] n;
    } ddrbc_rd_row_t;
    localparam ddrbc_rd_row_t ROWS [4] = '{
        '{3'h0, 14'h0123, 10'h005, 1'b1, 1'b1, 1'b0, 1'b1, 4'h8},
        '{3'h7, 14'h1fff, 10'h00e, 1'b0, 1'b1, 1'b1, 1'b0, 4'h4},
        '{3'h3, 14'h2000, 10'h3ff, 1'b0, 1'b0, 1'b1, 1'b0, 4'h8},
        '{3'h5, 14'h0abc, 10'h002, 1'b1, 1'b0, 1'b0, 1'b1, 4'h4}};
    logic clk_in, arst_n_in, cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in;
    logic otf_en_in, mrs_burst8_in, wdata_valid_in, wdata_ready_out, busy_out;
    logic self_refresh_out, rd_beat_out, wr_beat_out;
    logic [2:0] ba_in, rd_bank_out, wr_bank_out;
    logic [13:0] addr_in, refresh_row_out, wr_row_out;
    logic [15:0] wdata_in, wr_data_out;
    logic [1:0] dm_in, wr_byte_en_out;
    logic [7:0] bank_open_out;
    logic [9:0] rd_col_out, wr_col_out;
    logic [27:0] got [8];
    int failures, cmp_count, cycles, n, first;
    ddrbc_core uut (.clk_in, .arst_n_in, .cke_in, .cs_n_in, .ras_n_in, .cas_n_in,
        .we_n_in, .ba_in, .addr_in, .otf_en_in, .mrs_burst8_in, .wdata_in, .dm_in,
        .wdata_valid_in, .wdata_ready_out, .bank_open_out, .busy_out, .self_refresh_out,
        .refresh_row_out, .rd_beat_out, .rd_col_out, .rd_bank_out, .wr_beat_out,
        .wr_col_out, .wr_bank_out, .wr_row_out, .wr_data_out, .wr_byte_en_out);
    ddrbc_ctrl_model ctrl (.clk_in(clk_in), .cke_out(cke_in), .cs_n_out(cs_n_in),
        .ras_n_out(ras_n_in), .cas_n_out(cas_n_in), .we_n_out(we_n_in),
        .ba_out(ba_in), .addr_out(addr_in));
    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("failures=%0d compares=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    task automatic cmd(input ddrbc_cmd_t c, input logic [2:0] b, input logic [13:0] a);
        ctrl.issue(c, b, a);
        repeat (3) @(posedge clk_in);
        #1;
    endtask : cmd
    // Gathers beats over a fixed window after a command
    task automatic collect(input bit rd);
        n = 0;
        first = -1;
        for (int i = 0; i < 24; i++) begin
            @(posedge clk_in);
            #1;
            if ((rd ? rd_beat_out : wr_beat_out) === 1'b1) begin
                if (n == 0) first = i;
                if (n < 8) got[n] = rd ? {15'h0, rd_bank_out, rd_col_out} :
                    {wr_byte_en_out, wr_data_out, wr_col_out};
                n++;
            end
        end
    endtask : collect
    task automatic push(input logic [15:0] d, input logic [1:0] m);
        wdata_in = d;
        dm_in = m;
        wdata_valid_in = 1'b1;
        while (wdata_ready_out !== 1'b1) begin
            @(posedge clk_in);
            #1;
        end
        @(posedge clk_in);
        #1;
    endtask : push
    task automatic rst_check();
        check(bank_open_out, 8'h00);
        check(refresh_row_out, 14'h0000);
        check(self_refresh_out, 1'b0);
        check(busy_out, 1'b0);
        check(wdata_ready_out, 1'b1);
    endtask : rst_check
    function automatic logic [9:0] ecol(input logic [9:0] s, input logic [9:0] len, input int i);
        return (s & ~(len - 10'h1)) | ((s + 10'(i)) & (len - 10'h1));
    endfunction : ecol
    // --------------------------------------------------------------
    // Clock, timeout and main sequence
    // --------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        arst_n_in = 1'b0;
        otf_en_in = 1'b1;
        mrs_burst8_in = 1'b1;
        wdata_in = 16'h0000;
        dm_in = 2'h0;
        wdata_valid_in = 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
        rst_check();
        arst_n_in = 1'b1;
        for (int r = 0; r < 4; r++) begin
            otf_en_in = ROWS[r].otf;
            mrs_burst8_in = ROWS[r].b8;
            cmd(DDRBC_CMD_ACT, ROWS[r].ba, ROWS[r].row);
            check(bank_open_out[ROWS[r].ba], 1'b1);
            ctrl.issue(DDRBC_CMD_RD, ROWS[r].ba,
                {1'b0, ROWS[r].a12, 1'b0, ROWS[r].ap, ROWS[r].col});
            collect(1'b1);
            check(n, ROWS[r].n);
            check(first, 2);
            for (int i = 0; i < ROWS[r].n; i++) begin
                check(got[i], {ROWS[r].ba, ecol(ROWS[r].col, 10'(ROWS[r].n), i)});
            end
            check(bank_open_out[ROWS[r].ba], !ROWS[r].ap);
        end
        otf_en_in = 1'b1;
        cmd(DDRBC_CMD_ACT, 3'h1, 14'h0042);
        ctrl.issue(DDRBC_CMD_RD, 3'h1, 14'h1001);
        fork
            collect(1'b1);
            begin
                repeat (2) @(posedge clk_in);
                ctrl.issue(DDRBC_CMD_RD, 3'h1, 14'h1006);
            end
        join
        check(n, 8);
        check(got[7], {3'h1, 10'h000});
        ctrl.issue(DDRBC_CMD_RD, 3'h6, 14'h1000);
        collect(1'b1);
        check(n, 0);
        for (int i = 0; i < 8; i++) push(16'ha500 + 16'(i), 2'(i));
        wdata_valid_in = 1'b0;
        check(wdata_ready_out, 1'b0);
        cmd(DDRBC_CMD_ACT, 3'h2, 14'h0abc);
        ctrl.issue(DDRBC_CMD_WR, 3'h2, 14'h1000);
        collect(1'b0);
        check(n, 8);
        for (int i = 0; i < 8; i++) check(got[i], {~2'(i), 16'ha500 + 16'(i), 10'(i)});
        check(wr_row_out, 14'h0abc);
        check(wr_bank_out, 3'h2);
        check(wdata_ready_out, 1'b1);
        ctrl.issue(DDRBC_CMD_WR, 3'h2, 14'h0006);
        fork
            collect(1'b0);
            begin
                repeat (6) @(posedge clk_in);
                #1;
                check(busy_out, 1'b1);
                for (int i = 0; i < 4; i++) push(16'h5a00 + 16'(i), 2'h0);
                wdata_valid_in = 1'b0;
            end
        join
        check(n, 4);
        check(got[3], {2'h3, 16'h5a03, 10'h005});
        cmd(DDRBC_CMD_PRE, 3'h1, 14'h0000);
        check(bank_open_out, 8'h8c);
        cmd(DDRBC_CMD_PRE, 3'h6, 14'h0000);
        check(bank_open_out, 8'h8c);
        cmd(DDRBC_CMD_PRE, 3'h2, 14'h0400);
        check(bank_open_out, 8'h00);
        cmd(DDRBC_CMD_REF, 3'h5, 14'h3fff);
        cmd(DDRBC_CMD_REF, 3'h0, 14'h0000);
        check(refresh_row_out, 14'h0002);
        ctrl.issue(DDRBC_CMD_SRE, 3'h0, 14'h0000);
        repeat (1200) @(posedge clk_in);
        #1;
        check(self_refresh_out, 1'b1);
        check(refresh_row_out, 14'h0003);
        ctrl.issue(DDRBC_CMD_NOP, 3'h0, 14'h0000);
        repeat (6) @(posedge clk_in);
        #1;
        check(self_refresh_out, 1'b0);
        // Banks were all closed before this open, as the controller must ensure
        cmd(DDRBC_CMD_ACT, 3'h4, 14'h0001);
        check(bank_open_out, 8'h10);
        // Write with an empty buffer stalls; reset lands in mid-burst
        cmd(DDRBC_CMD_WR, 3'h4, 14'h0000);
        check(busy_out, 1'b1);
        arst_n_in = 1'b0;
        #1;
        rst_check();
        arst_n_in = 1'b1;
        cmd(DDRBC_CMD_ACT, 3'h5, 14'h0002);
        check(bank_open_out, 8'h20);
        conclude();
    end
endmodule : tb_ddr3_bank_command_logic
